/* File: rtl/nicrpc_pkg.sv */
/*
 * package for the interrupt, reset and power-down control block:
 * field positions, reset values, power states and carrier structs.
 * assumes nothing of its surroundings.
 */
package nicrpc_pkg;
    // ==========================================================
    // widths and reset values
    localparam int unsigned IRQ_SRC_W = 8;
    localparam int unsigned LOCAL_IRQ_N = 4;
    localparam int unsigned CODEC_SEL_W = 2;
    localparam logic [1:0] LOCAL_SEL_RST = 2'h0;
    localparam logic [CODEC_SEL_W-1:0] CODEC_OFF = 2'h0;
    // settle count from reset release to card ready (cycles)
    localparam logic [3:0] READY_WAIT_CYC = 4'h8;

    // ==========================================================
    // power states
    typedef enum logic [1:0] {
        NICRPC_AWAKE,
        NICRPC_TX_OFF,
        NICRPC_ETH_OFF,
        NICRPC_ALL_OFF
    } nicrpc_pwr_t;

    // host-side control bits
    typedef struct packed {
        logic cfg_soft_reset;    // config_soft_reset_bit
        logic mac_soft_reset;    // soft reset in receive_control_register
        logic eth_irq_enable;    // config_option_register interrupt enable
        logic func_enable;       // config_option_register function enable
        logic legacy_powerdown;  // legacy_powerdown_bit
        logic wakeup_enable;     // wakeup_enable_bit
        logic [1:0] local_sel;   // which local_interrupt_outputs line
    } nicrpc_ctl_t;

    // reset and power-down strobes to the rest of the chip
    typedef struct packed {
        logic eth_ctl_reset;     // ethernet_protocol_handler reset
        logic card_cfg_reset;    // card configuration registers
        logic keep_addr_regs;    // individual/config/address_register_a kept
        logic cfg_mem_read;      // start configuration memory read
        logic tx_down;
        logic rx_down;
        logic link_down;
        logic all_down;
    } nicrpc_pwr_out_t;
endpackage

/* File: rtl/nicrpc_ctl.sv */
/*
 * interrupt merge, reset distribution and power-down sequencing.
 * assumes: host bits arrive on the same clock; pins and the bus mode
 * strap come from outside and are synchronised here.
 */
`timescale 1ns/1ns
module nicrpc_ctl #(
    parameter int unsigned SRC_W = nicrpc_pkg::IRQ_SRC_W
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // pins from outside
    input wire logic i_card_mode_strap,
    input wire logic i_powerdown_input,
    // interrupt sources from the ethernet core
    input wire logic [SRC_W-1:0] i_irq_status,
    input wire logic [SRC_W-1:0] i_irq_enable,
    // host control bits
    input wire nicrpc_pkg::nicrpc_ctl_t i_ctl,
    input wire logic [nicrpc_pkg::CODEC_SEL_W-1:0] i_external_codec_select,
    input wire logic i_cfg_mem_busy,
    // interrupt outputs
    output logic o_card_interrupt_request_n,
    output logic [nicrpc_pkg::LOCAL_IRQ_N-1:0] o_local_interrupt_outputs,
    output logic o_status_intr,
    output logic o_card_mode,
    // reset and power outputs
    output nicrpc_pkg::nicrpc_pwr_out_t o_pwr,
    output nicrpc_pkg::nicrpc_pwr_t o_pwr_state,
    output logic o_modem_powerdown_output_n
);
    // ==========================================================
    // pin synchronisers
    logic strap_m_q, strap_s_q, pd_m_q, pd_s_q;
    // strap sync runs through reset so the first edge after release
    // already sees the settled strap level
    always_ff @(posedge i_sys_clk) begin
        strap_m_q <= i_card_mode_strap;
        strap_s_q <= strap_m_q;
    end

    // power-down pin sync, cleared in reset
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pd_m_q <= 1'b0;
            pd_s_q <= 1'b0;
        end else begin
            pd_m_q <= i_powerdown_input;
            pd_s_q <= pd_m_q;
        end
    end

    // ==========================================================
    // mode strap, ready and reset strobes
    logic card_mode_q, card_mode_d;
    logic strap_done_q, strap_done_d;
    logic ready_q, ready_d;
    logic [3:0] wait_q, wait_d;
    logic cfg_rst_q, cfg_rst_d;
    logic mem_rd_q, mem_rd_d;

    // strap caught once after release; soft resets never resample it
    always_comb begin
        card_mode_d = card_mode_q;
        strap_done_d = 1'b1;
        if (!strap_done_q) begin
            card_mode_d = strap_s_q;
        end
        cfg_rst_d = i_ctl.cfg_soft_reset;
        // memory read once on reset release and on rising config soft reset;
        // holding the bit set starts no further reads
        mem_rd_d = (i_ctl.cfg_soft_reset && !cfg_rst_q)
            || !strap_done_q;
        // ready after settle wait and memory read; config reset drops it
        wait_d = wait_q;
        ready_d = ready_q;
        if (i_ctl.cfg_soft_reset) begin
            ready_d = 1'b0;
            wait_d = nicrpc_pkg::READY_WAIT_CYC;
        end else if (wait_q != 4'h0) begin
            wait_d = wait_q - 4'h1;
        end else if (!i_cfg_mem_busy && !mem_rd_q) begin
            ready_d = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            card_mode_q <= 1'b0;
            strap_done_q <= 1'b0;
            ready_q <= 1'b0;
            wait_q <= nicrpc_pkg::READY_WAIT_CYC;
            cfg_rst_q <= 1'b0;
            mem_rd_q <= 1'b0;
        end else begin
            card_mode_q <= card_mode_d;
            strap_done_q <= strap_done_d;
            ready_q <= ready_d;
            wait_q <= wait_d;
            cfg_rst_q <= cfg_rst_d;
            mem_rd_q <= mem_rd_d;
        end
    end

    // ==========================================================
    // interrupt merge
    logic merged;
    logic card_irq_n_d, stat_d;
    logic [nicrpc_pkg::LOCAL_IRQ_N-1:0] local_d;
    logic card_irq_n_q, stat_q;
    logic [nicrpc_pkg::LOCAL_IRQ_N-1:0] local_q;

    always_comb begin
        merged = |(i_irq_status & i_irq_enable);
        stat_d = merged;
        // enable gates card mode only
        card_irq_n_d = !(card_mode_q && merged && i_ctl.eth_irq_enable);
        local_d = '0;
        if (!card_mode_q) begin
            local_d[i_ctl.local_sel] = merged;
        end
        // ready line forced low while not ready, and at once when the
        // config soft reset is set, not a cycle later through ready
        if (!ready_q || i_ctl.cfg_soft_reset) begin
            card_irq_n_d = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            card_irq_n_q <= 1'b0;
            local_q <= '0;
            stat_q <= 1'b0;
        end else begin
            card_irq_n_q <= card_irq_n_d;
            local_q <= local_d;
            stat_q <= stat_d;
        end
    end

    // ==========================================================
    // power state
    nicrpc_pkg::nicrpc_pwr_t state_q, state_d;
    nicrpc_pkg::nicrpc_pwr_out_t pwr_q, pwr_d;
    logic modem_n_q, modem_n_d;
    logic pin_down;

    always_comb begin
        pin_down = pd_s_q && (i_external_codec_select != nicrpc_pkg::CODEC_OFF);
        // function enable is not consulted here
        if (pin_down) begin
            state_d = nicrpc_pkg::NICRPC_ALL_OFF;
        end else if (i_ctl.legacy_powerdown) begin
            state_d = nicrpc_pkg::NICRPC_ETH_OFF;
        end else if (i_ctl.wakeup_enable) begin
            state_d = nicrpc_pkg::NICRPC_TX_OFF;
        end else begin
            state_d = nicrpc_pkg::NICRPC_AWAKE;
        end
        pwr_d = '0;
        case (state_d)
            nicrpc_pkg::NICRPC_ALL_OFF: begin
                pwr_d.all_down = 1'b1;
                pwr_d.tx_down = 1'b1;
                pwr_d.rx_down = 1'b1;
                pwr_d.link_down = 1'b1;
            end
            nicrpc_pkg::NICRPC_ETH_OFF: begin
                pwr_d.tx_down = 1'b1;
                pwr_d.rx_down = 1'b1;
                pwr_d.link_down = 1'b1;
            end
            nicrpc_pkg::NICRPC_TX_OFF: begin
                pwr_d.tx_down = 1'b1;
            end
            default: begin
                pwr_d.tx_down = 1'b0;
            end
        endcase
        // config reset hits controller and card regs; mac reset keeps addresses
        pwr_d.eth_ctl_reset = i_ctl.cfg_soft_reset || i_ctl.mac_soft_reset;
        pwr_d.card_cfg_reset = i_ctl.cfg_soft_reset;
        pwr_d.keep_addr_regs = i_ctl.mac_soft_reset && !i_ctl.cfg_soft_reset;
        pwr_d.cfg_mem_read = mem_rd_q;
        // modem power-down pin low only with everything down
        modem_n_d = !pwr_d.all_down;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= nicrpc_pkg::NICRPC_AWAKE;
            pwr_q <= '0;
            modem_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            pwr_q <= pwr_d;
            modem_n_q <= modem_n_d;
        end
    end

    // outputs straight from flip-flops
    assign o_card_interrupt_request_n = card_irq_n_q;
    assign o_local_interrupt_outputs = local_q;
    assign o_status_intr = stat_q;
    assign o_card_mode = card_mode_q;
    assign o_pwr = pwr_q;
    assign o_pwr_state = state_q;
    assign o_modem_powerdown_output_n = modem_n_q;
endmodule

/* File: tb/nicrpc_asserts.sv */
/* checker on the ports of the control block: interrupt merge, resets, power states.
   assumes it is bound into nicrpc_ctl and sees its ports by name. */
`timescale 1ns/1ns
module nicrpc_asserts #(
    parameter int unsigned SRC_W = nicrpc_pkg::IRQ_SRC_W
) (
    // clock, reset and inputs
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_powerdown_input,
    input wire logic [SRC_W-1:0] i_irq_status,
    input wire logic [SRC_W-1:0] i_irq_enable,
    input wire nicrpc_pkg::nicrpc_ctl_t i_ctl,
    input wire logic [nicrpc_pkg::CODEC_SEL_W-1:0] i_external_codec_select,
    // outputs
    input wire logic o_card_interrupt_request_n,
    input wire logic [nicrpc_pkg::LOCAL_IRQ_N-1:0] o_local_interrupt_outputs,
    input wire logic o_status_intr,
    input wire logic o_card_mode,
    input wire nicrpc_pkg::nicrpc_pwr_out_t o_pwr,
    input wire nicrpc_pkg::nicrpc_pwr_t o_pwr_state,
    input wire logic o_modem_powerdown_output_n
);
    // ==========================================================
    // one clock domain, disabled in reset
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // pin held asserted with the codec selected
    sequence s_pin_held;
        (i_powerdown_input && i_external_codec_select != 2'h0) [*4];
    endsequence
    a_irq_merge: assert property (!$past(i_rst) |->
        o_status_intr == |$past(i_irq_status & i_irq_enable)) else $error("merge wrong");
    a_local_line: assert property (!$past(i_rst) && !o_card_mode |->
        o_local_interrupt_outputs == ({3'h0, o_status_intr} << $past(i_ctl.local_sel)))
        else $error("local line wrong");
    a_soft_low: assert property (!$past(i_rst) && $past(i_ctl.cfg_soft_reset) &&
        o_card_mode |-> !o_card_interrupt_request_n) else $error("ready line not low");
    a_cfg_reset: assert property (!$past(i_rst) && $past(i_ctl.cfg_soft_reset) |->
        o_pwr.eth_ctl_reset && o_pwr.card_cfg_reset) else $error("config reset missing");
    a_mac_keep: assert property (!$past(i_rst) && $past(i_ctl.mac_soft_reset) &&
        !$past(i_ctl.cfg_soft_reset) |-> o_pwr.eth_ctl_reset && o_pwr.keep_addr_regs &&
        !o_pwr.card_cfg_reset) else $error("mac reset wrong");
    a_pin_all: assert property (s_pin_held |=> o_pwr.all_down &&
        !o_modem_powerdown_output_n && o_pwr_state == nicrpc_pkg::NICRPC_ALL_OFF)
        else $error("pin power-down missing");
    a_codec_off: assert property ((i_external_codec_select == 2'h0) [*5] |->
        o_modem_powerdown_output_n && !o_pwr.all_down) else $error("pin not ignored");
    a_legacy_off: assert property (!$past(i_rst) && $past(i_ctl.legacy_powerdown) &&
        o_pwr_state != nicrpc_pkg::NICRPC_ALL_OFF |-> o_pwr[3:1] == 3'h7 &&
        o_pwr_state == nicrpc_pkg::NICRPC_ETH_OFF) else $error("legacy state wrong");
    a_tx_only: assert property (!$past(i_rst) && $past(i_ctl.wakeup_enable) &&
        !$past(i_ctl.legacy_powerdown) && o_pwr_state != nicrpc_pkg::NICRPC_ALL_OFF |->
        o_pwr[3:1] == 3'h4 && o_pwr_state == nicrpc_pkg::NICRPC_TX_OFF)
        else $error("tx-only state wrong");
endmodule
bind nicrpc_ctl nicrpc_asserts #(.SRC_W(SRC_W)) u_asserts (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_powerdown_input(i_powerdown_input),
    .i_irq_status(i_irq_status),
    .i_irq_enable(i_irq_enable),
    .i_ctl(i_ctl),
    .i_external_codec_select(i_external_codec_select),
    .o_card_interrupt_request_n(o_card_interrupt_request_n),
    .o_local_interrupt_outputs(o_local_interrupt_outputs),
    .o_status_intr(o_status_intr),
    .o_card_mode(o_card_mode),
    .o_pwr(o_pwr),
    .o_pwr_state(o_pwr_state),
    .o_modem_powerdown_output_n(o_modem_powerdown_output_n)
);

/* File: tb/nicrpc_host_model.sv */
/* host model: holds the control bits the host processor has written.
   assumes the bench raises i_wr for one cycle with the new bits. */
`timescale 1ns/1ns
module nicrpc_host_model (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // write from the bench
    input wire logic i_wr,
    input wire nicrpc_pkg::nicrpc_ctl_t i_data,
    // bits to the block
    output nicrpc_pkg::nicrpc_ctl_t o_ctl
);
    // ==========================================================
    // control latch; holds no status power-down bit to set
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ctl <= '0;
        end else if (i_wr) begin
            o_ctl <= i_data;
        end
    end
endmodule

/* File: tb/nicrpc_ctl_tb_top.sv */
/* directed bench for nicrpc_ctl with a host model.
   assumes a 20 MHz clock and an 8-cycle reset made here. */
`timescale 1ns/1ns
module nicrpc_ctl_tb_top;
    // ==========================================================
    // stimulus and observed signals
    logic clk = 1'b0, rst = 1'b1, strap = 1'b0, pin = 1'b0, wr = 1'b0, busy = 1'b0, rd_seen;
    logic [7:0] st = 8'h0, en = 8'h0, wd = 8'h0;
    logic [1:0] codec = 2'h0;
    logic irq_n, status, cmode, modem_n;
    logic [3:0] lirq;
    nicrpc_pkg::nicrpc_ctl_t ctl;
    nicrpc_pkg::nicrpc_pwr_out_t pwr;
    nicrpc_pkg::nicrpc_pwr_t state;
    int fail_count = 0, n_compared = 0, cyc = 0;
    // clock, timeout, memory-read pulse catcher
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (pwr.cfg_mem_read) rd_seen = 1'b1;
        if (cyc == 3000) begin
            fail_count++;
            summarize();
        end
    end
    nicrpc_host_model host (.i_sys_clk(clk), .i_rst(rst), .i_wr(wr), .i_data(wd), .o_ctl(ctl));
    nicrpc_ctl dut (.i_sys_clk(clk), .i_rst(rst), .i_card_mode_strap(strap),
        .i_powerdown_input(pin), .i_irq_status(st), .i_irq_enable(en), .i_ctl(ctl),
        .i_external_codec_select(codec), .i_cfg_mem_busy(busy),
        .o_card_interrupt_request_n(irq_n), .o_local_interrupt_outputs(lirq),
        .o_status_intr(status), .o_card_mode(cmode), .o_pwr(pwr), .o_pwr_state(state),
        .o_modem_powerdown_output_n(modem_n));
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic put(input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        wd <= v;
        @(posedge clk);
        wr <= 1'b0;
        w(3);
    endtask
    task automatic drive(input logic p, input logic [1:0] c, input logic [7:0] s, e);
        @(posedge clk);
        pin <= p;
        codec <= c;
        st <= s;
        en <= e;
        w(6);
    endtask
    task automatic do_reset(input logic s);
        @(posedge clk);
        rst <= 1'b1;
        strap <= s;
        w(7);
        @(posedge clk);
        rst <= 1'b0;
        w(20);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_local();
        chk(cmode, 8'h0);
        drive(1'b0, 2'h0, 8'h24, 8'h20);
        for (int i = 0; i < 4; i++) begin
            put({6'h0, i[1:0]});
            chk({status, lirq}, 8'h10 | (8'h1 << i));
        end
        drive(1'b0, 2'h0, 8'h24, 8'h1b);
        chk({status, lirq}, 8'h0);
    endtask
    task automatic t_power();
        put(8'h08);
        chk({state, pwr[3:0]}, 8'h2e);
        put(8'h18);
        chk(state, nicrpc_pkg::NICRPC_ETH_OFF);
        drive(1'b1, 2'h0, 8'h0, 8'h0);
        chk({modem_n, state}, 8'h6);
        drive(1'b1, 2'h1, 8'h0, 8'h0);
        put(8'h00);
        chk({modem_n, pwr[0], state}, 8'h7);
        put(8'h08);
        drive(1'b0, 2'h1, 8'h0, 8'h0);
        chk({modem_n, state}, 8'h6);
        put(8'h0c);
        put(8'h04);
        chk({state, pwr[3:0]}, 8'h18);
        put(8'h00);
        chk({state, pwr[3:0]}, 8'h0);
        put(8'h0c);
        put(8'h08);
        chk(state, nicrpc_pkg::NICRPC_ETH_OFF);
        put(8'h00);
        chk({state, pwr[3:0]}, 8'h0);
        rd_seen = 1'b0;
        put(8'h40);
        chk({rd_seen, pwr[7:5]}, 8'h5);
        put(8'h00);
    endtask
    task automatic t_card();
        @(posedge clk);
        busy <= 1'b1;
        rd_seen = 1'b0;
        do_reset(1'b1);
        chk({rd_seen, cmode, irq_n}, 8'h6);
        @(posedge clk);
        busy <= 1'b0;
        w(20);
        chk(irq_n, 8'h1);
        drive(1'b0, 2'h0, 8'h01, 8'h01);
        chk({status, irq_n}, 8'h3);
        put(8'h20);
        chk({irq_n, lirq}, 8'h0);
        rd_seen = 1'b0;
        put(8'h80);
        chk({rd_seen, irq_n, pwr[7:6]}, 8'hb);
        put(8'h00);
        w(15);
        chk(irq_n, 8'h1);
    endtask
    task automatic summarize();
        if (fail_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        do_reset(1'b0);
        t_local();
        t_power();
        t_card();
        summarize();
    end
endmodule
